// ### flash_section_access_guard.sv
// Purpose: Guards self-programming of program flash by section and lock bits
// Assumes: Core requests, flash done and config come from core_clk_in logic
// Notes: Section boundaries are static; lock bits hold until chip erase or reset
//
// What this block does
// - Concurrent-section programming keeps halting-section reads going
// - Halting-section programming halts core throughout
// - Locks set by software/programming; chip erase clears
// - General write lock ignores store programming
// - General read/write lock ignores load and store
// - Lock pair all ones means unrestricted
// - Application write lock refuses application stores
// - Application read lock blocks loader-issued loads
// - Application read lock masks interrupts in application when vectors are in loader
// - Loader write lock refuses loader stores
// - Loader read lock blocks application-issued loads
// - Loader read lock masks interrupts in loader when vectors are not in loader
// - Lock bit one unprogrammed, zero programmed
// - Store programs only when executed from loader
// - Busy flag set while concurrent section blocked
`include "flash_guard_defines.svh"

module flash_section_access_guard (
    input wire logic core_clk_in, // Core clock, 40 MHz
    input wire logic rst_in, // Async reset, active high
    // Register port
    input wire logic [`REG_ADDR_W-1:0] reg_addr_in, // Register byte address
    input wire logic [`REG_DATA_W-1:0] reg_wdata_in, // Register write data
    input wire logic reg_wr_in, // Register write strobe
    input wire logic reg_rd_in, // Register read strobe
    output logic [`REG_DATA_W-1:0] reg_rdata_out, // Read data, cycle after strobe
    // Core requests
    input flash_guard_pkg::store_req_t store_req_in, // Store operation request
    input flash_guard_pkg::load_req_t load_req_in, // Load operation request
    input flash_guard_pkg::flash_addr_t exec_pc_in, // Address now executing
    input flash_guard_pkg::section_cfg_t section_cfg_in, // Static boundaries
    // Programming paths
    input wire logic ext_lock_wr_in, // Serial/parallel lock write
    input wire logic [`LOCK_FIELD_W-1:0] ext_lock_data_in, // Lock data, 0 programs
    input wire logic chip_erase_in, // Chip erase command
    // Flash array
    input wire logic flash_done_in, // Erase or write finished
    output flash_guard_pkg::flash_cmd_t flash_cmd_out, // Commands to flash array
    // Core controls
    output logic core_halt_out, // Core halted
    output logic load_grant_out, // Load allowed, cycle after request
    output logic load_block_out, // Load blocked, cycle after request
    output logic store_refused_out, // Store refused, cycle after request
    output logic irq_disable_out, // Interrupts masked
    output logic concurrent_section_busy_flag_out, // Concurrent section blocked
    output flash_guard_pkg::lock_bits_t locks_out // Current lock bits
);
    import flash_guard_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    prog_state_t state_reg;
    prog_state_t state_next;
    lock_bits_t locks_reg;
    lock_bits_t locks_next;
    logic busy_flag_reg;
    logic busy_flag_next;
    logic target_halting_reg;
    logic target_halting_next;
    flash_cmd_t cmd_reg;
    flash_cmd_t cmd_next;
    logic halt_reg;
    logic grant_reg;
    logic block_reg;
    logic refused_reg;
    logic irq_off_reg;
    logic [`REG_DATA_W-1:0] rdata_reg;
    logic [`REG_DATA_W-1:0] rdata_next;

    // ----------------------------------------
    // Decode of the current requests
    // ----------------------------------------
    access_perm_t perm;

    flash_lock_decode u_decode (
        .locks_in(locks_reg),
        .cfg_in(section_cfg_in),
        .store_addr_in(store_req_in.addr),
        .load_addr_in(load_req_in.addr),
        .load_pc_in(load_req_in.pc),
        .pc_in(exec_pc_in),
        .perm_out(perm)
    );

    function automatic logic at_or_above(input flash_addr_t a, input flash_addr_t start);
        at_or_above = (a >= start);
    endfunction

    wire idle = (state_reg == ST_IDLE);
    wire from_loader = at_or_above(store_req_in.pc, section_cfg_in.loader_start);
    wire store_live = store_req_in.valid & idle & from_loader;
    wire is_prog_op = (store_req_in.op == STORE_ERASE) | (store_req_in.op == STORE_WRITE);
    wire store_target_halting = at_or_above(store_req_in.addr, section_cfg_in.halting_start);
    wire prog_start = store_live & is_prog_op & perm.allow_store;
    wire buf_load = store_live & (store_req_in.op == STORE_BUF_LOAD);
    wire lock_set_core = store_live & (store_req_in.op == STORE_LOCK_SET);
    wire reenable_core = store_live & (store_req_in.op == STORE_REENABLE);
    wire store_refused = store_req_in.valid & ~(store_live & (~is_prog_op | perm.allow_store));

    // ----------------------------------------
    // Register port decode
    // ----------------------------------------
    wire wr_lock = reg_wr_in & (reg_addr_in == `REG_LOCK_OFS);
    wire wr_ctrl = reg_wr_in & (reg_addr_in == `REG_CTRL_OFS);
    wire reenable_sw = wr_ctrl & reg_wdata_in[`CTRL_REENABLE_BIT];
    wire [`LOCK_FIELD_W-1:0] sw_lock_data = reg_wdata_in[`LOCK_FIELD_W-1:0];

    // Writes only clear bits
    wire [`LOCK_FIELD_W-1:0] lock_and_mask =
        (wr_lock ? sw_lock_data : `LOCK_ERASED_VAL) &
        (lock_set_core ? store_req_in.lock_data : `LOCK_ERASED_VAL) &
        (ext_lock_wr_in ? ext_lock_data_in : `LOCK_ERASED_VAL);

    wire [`REG_DATA_W-1:0] status_word = {
        {(`REG_DATA_W-`STAT_FIELD_W){1'b0}},
        target_halting_reg,
        halt_reg,
        ~idle,
        busy_flag_reg
    };

    // ----------------------------------------
    // Lock bits
    // ----------------------------------------
    always_comb begin
        if (chip_erase_in) begin
            locks_next = lock_bits_t'(`LOCK_ERASED_VAL);
        end else begin
            locks_next = lock_bits_t'(locks_reg & lock_and_mask);
        end
    end

    // ----------------------------------------
    // Programming sequencer
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        target_halting_next = target_halting_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (prog_start) begin
                    state_next = ST_PROG;
                    target_halting_next = store_target_halting;
                end
            end
            ST_PROG: begin
                if (flash_done_in) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Concurrent section busy flag
    // ----------------------------------------
    // Start wins over a clear in the same cycle
    always_comb begin
        busy_flag_next = busy_flag_reg;
        if (prog_start & ~store_target_halting) begin
            busy_flag_next = 1'b1;
        end else if (idle & (reenable_sw | reenable_core | buf_load)) begin
            busy_flag_next = 1'b0;
        end
    end

    // ----------------------------------------
    // Flash commands, one cycle pulses
    // ----------------------------------------
    always_comb begin
        cmd_next.erase = prog_start & (store_req_in.op == STORE_ERASE);
        cmd_next.write = prog_start & (store_req_in.op == STORE_WRITE);
        cmd_next.buf_load = buf_load;
        cmd_next.addr = cmd_reg.addr;
        if (prog_start | buf_load) begin
            cmd_next.addr = store_req_in.addr;
        end
    end

    // Halt starts with the command and lasts to done
    wire halt_next = (prog_start & store_target_halting) |
                     (~idle & target_halting_reg & ~flash_done_in);

    // Loads into the concurrent section are blocked while the flag is set
    wire load_in_concurrent = ~at_or_above(load_req_in.addr, section_cfg_in.halting_start);
    wire load_ok = perm.allow_load & ~(load_in_concurrent & busy_flag_reg);

    // ----------------------------------------
    // Read data mux
    // ----------------------------------------
    always_comb begin
        rdata_next = '0;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                `REG_LOCK_OFS: rdata_next = {{(`REG_DATA_W-`LOCK_FIELD_W){1'b0}}, locks_reg};
                `REG_STATUS_OFS: rdata_next = status_word;
                default: rdata_next = '0;
            endcase
        end
    end

    // ----------------------------------------
    // Flip-flops
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            locks_reg <= lock_bits_t'(`LOCK_RESET_VAL);
            busy_flag_reg <= 1'b0;
            target_halting_reg <= 1'b0;
            cmd_reg <= '0;
        end else begin
            state_reg <= state_next;
            locks_reg <= locks_next;
            busy_flag_reg <= busy_flag_next;
            target_halting_reg <= target_halting_next;
            cmd_reg <= cmd_next;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            halt_reg <= 1'b0;
            grant_reg <= 1'b0;
            block_reg <= 1'b0;
            refused_reg <= 1'b0;
            irq_off_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            halt_reg <= halt_next;
            rdata_reg <= rdata_next;
            grant_reg <= load_req_in.valid & load_ok;
            block_reg <= load_req_in.valid & ~load_ok;
            refused_reg <= store_refused;
            irq_off_reg <= perm.irq_off;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_out = rdata_reg;
    assign flash_cmd_out = cmd_reg;
    assign core_halt_out = halt_reg;
    assign load_grant_out = grant_reg;
    assign load_block_out = block_reg;
    assign store_refused_out = refused_reg;
    assign irq_disable_out = irq_off_reg;
    assign concurrent_section_busy_flag_out = busy_flag_reg;
    assign locks_out = locks_reg;

endmodule // flash_section_access_guard

// ### flash_guard_defines.svh
// Purpose: Constants for the flash section access guard
// Assumes: Included by the package and the design modules
// Notes: Register offsets are byte addresses on the plain register port
`ifndef FLASH_GUARD_DEFINES_SVH
`define FLASH_GUARD_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define FLASH_ADDR_W 16
`define REG_ADDR_W 8
`define REG_DATA_W 32

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_LOCK_OFS 8'h00
`define REG_CTRL_OFS 8'h04
`define REG_STATUS_OFS 8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LOCK_FIELD_W 6
`define CTRL_REENABLE_BIT 0
`define STAT_FIELD_W 4

// ----------------------------------------
// Reset values (1 means unprogrammed)
// ----------------------------------------
`define LOCK_RESET_VAL 6'h3f
`define LOCK_ERASED_VAL 6'h3f

`endif

// ### flash_guard_pkg.sv
// Purpose: Types for the flash section access guard
// Assumes: flash_guard_defines.svh gives the widths
// Notes: Lock bits hold 1 when unprogrammed
`include "flash_guard_defines.svh"

package flash_guard_pkg;

    // ----------------------------------------
    // Basic types
    // ----------------------------------------
    typedef logic [`FLASH_ADDR_W-1:0] flash_addr_t;

    typedef struct packed {
        logic read_lock;
        logic write_lock;
    } lock_pair_t;

    typedef struct packed {
        logic [1:0] general;
        lock_pair_t loader_lock_pair;
        lock_pair_t application_lock_pair;
    } lock_bits_t;

    // Store operation codes
    typedef enum logic [2:0] {
        STORE_BUF_LOAD = 3'h0,
        STORE_ERASE = 3'h1,
        STORE_WRITE = 3'h2,
        STORE_LOCK_SET = 3'h3,
        STORE_REENABLE = 3'h4
    } store_op_t;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        store_op_t op;
        flash_addr_t addr;
        flash_addr_t pc;
        logic [`LOCK_FIELD_W-1:0] lock_data;
    } store_req_t;

    typedef struct packed {
        logic valid;
        flash_addr_t addr;
        flash_addr_t pc;
    } load_req_t;

    typedef struct packed {
        flash_addr_t loader_start;
        flash_addr_t halting_start;
        logic vectors_in_loader;
    } section_cfg_t;

    typedef struct packed {
        logic erase;
        logic write;
        logic buf_load;
        flash_addr_t addr;
    } flash_cmd_t;

    typedef struct packed {
        logic allow_store;
        logic allow_load;
        logic irq_off;
    } access_perm_t;

    // Programming sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PROG = 2'b10
    } prog_state_t;

endpackage

// ### flash_lock_decode.sv
// Purpose: Decodes the two lock pairs into access permissions
// Assumes: Purely combinational, same clock as the caller
// Notes: Permissions for one store target, one load target and the current pc
`include "flash_guard_defines.svh"

module flash_lock_decode (
    input flash_guard_pkg::lock_bits_t locks_in, // Current lock bits
    input flash_guard_pkg::section_cfg_t cfg_in, // Section boundaries
    input flash_guard_pkg::flash_addr_t store_addr_in, // Store target
    input flash_guard_pkg::flash_addr_t load_addr_in, // Load target
    input flash_guard_pkg::flash_addr_t load_pc_in, // Address issuing the load
    input flash_guard_pkg::flash_addr_t pc_in, // Executing address
    output flash_guard_pkg::access_perm_t perm_out // Decoded permissions
);
    import flash_guard_pkg::*;

    // ----------------------------------------
    // Section classification
    // ----------------------------------------
    function automatic logic in_loader(input flash_addr_t a, input flash_addr_t start);
        in_loader = (a >= start);
    endfunction

    wire pc_in_loader = in_loader(pc_in, cfg_in.loader_start);
    wire store_to_loader = in_loader(store_addr_in, cfg_in.loader_start);
    wire load_from_loader = in_loader(load_addr_in, cfg_in.loader_start);
    wire load_pc_loader = in_loader(load_pc_in, cfg_in.loader_start);

    // ----------------------------------------
    // Lock pair decode, 0 means programmed
    // ----------------------------------------
    wire app_write_blocked = ~locks_in.application_lock_pair.write_lock;
    wire app_read_blocked = ~locks_in.application_lock_pair.read_lock;
    wire ldr_write_blocked = ~locks_in.loader_lock_pair.write_lock;
    wire ldr_read_blocked = ~locks_in.loader_lock_pair.read_lock;

    // General lock bits take no part here
    wire store_ok = store_to_loader ? ~ldr_write_blocked : ~app_write_blocked;
    wire load_ok = ~((load_pc_loader & ~load_from_loader & app_read_blocked) |
                     (~load_pc_loader & load_from_loader & ldr_read_blocked));
    wire irq_off = (app_read_blocked & cfg_in.vectors_in_loader & ~pc_in_loader) |
                   (ldr_read_blocked & ~cfg_in.vectors_in_loader & pc_in_loader);

    assign perm_out.allow_store = store_ok;
    assign perm_out.allow_load = load_ok;
    assign perm_out.irq_off = irq_off;

endmodule // flash_lock_decode

// ### flash_guard_props.sv
// Purpose: Port assertions for the flash section access guard
// Assumes: Bound to flash_section_access_guard
// Notes: Boundaries come from section_cfg_in
`include "flash_guard_defines.svh"

module flash_guard_props (
    input wire logic core_clk_in, // Clock
    input wire logic rst_in, // Reset
    input flash_guard_pkg::store_req_t store_req_in, // Store
    input flash_guard_pkg::load_req_t load_req_in, // Load
    input flash_guard_pkg::flash_addr_t exec_pc_in, // Executing pc
    input flash_guard_pkg::section_cfg_t section_cfg_in, // Boundaries
    input wire logic chip_erase_in, // Chip erase
    input wire logic flash_done_in, // Flash done
    input flash_guard_pkg::flash_cmd_t flash_cmd_out, // Flash command
    input logic core_halt_out, // Halt
    input logic load_grant_out, // Grant
    input logic load_block_out, // Block
    input logic store_refused_out, // Refused
    input logic irq_disable_out, // Irq mask
    input logic concurrent_section_busy_flag_out, // Busy flag
    input flash_guard_pkg::lock_bits_t locks_out // Locks
);
    timeunit 1ns;
    timeprecision 100ps;
    import flash_guard_pkg::*;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    wire st_ldr = store_req_in.pc >= section_cfg_in.loader_start;
    wire st_tgt_ldr = store_req_in.addr >= section_cfg_in.loader_start;
    wire st_prog = store_req_in.valid && (store_req_in.op == STORE_ERASE || store_req_in.op == STORE_WRITE);
    wire ld_ldr = load_req_in.pc >= section_cfg_in.loader_start;
    wire ld_tgt_ldr = load_req_in.addr >= section_cfg_in.loader_start;
    wire pc_ldr = exec_pc_in >= section_cfg_in.loader_start;
    wire busy = concurrent_section_busy_flag_out;
    wire prog_cmd = flash_cmd_out.erase || flash_cmd_out.write;

    a_app_store_ignored: assert property (st_prog && !st_ldr |=> store_refused_out && !prog_cmd)
        else $error("app store acted");
    a_halt_holds: assert property (core_halt_out && !flash_done_in |=> core_halt_out)
        else $error("halt dropped early");
    a_halt_cause: assert property ($rose(core_halt_out) |-> $past(store_req_in.valid))
        else $error("halt without store");
    a_app_write_lock: assert property (st_prog && !st_tgt_ldr && !locks_out.application_lock_pair.write_lock
        |=> !prog_cmd) else $error("app store ran");
    a_ldr_write_lock: assert property (st_prog && st_tgt_ldr && !locks_out.loader_lock_pair.write_lock
        |=> !prog_cmd) else $error("loader store ran");
    a_app_read_lock: assert property (load_req_in.valid && ld_ldr && !ld_tgt_ldr
        && !locks_out.application_lock_pair.read_lock |=> load_block_out && !load_grant_out)
        else $error("app read not blocked");
    a_ldr_read_lock: assert property (load_req_in.valid && !ld_ldr && ld_tgt_ldr
        && !locks_out.loader_lock_pair.read_lock |=> load_block_out && !load_grant_out)
        else $error("loader read not blocked");
    a_open_load: assert property (load_req_in.valid && locks_out[3:0] == 4'hf
        && load_req_in.addr >= section_cfg_in.halting_start |=> load_grant_out) else $error("open load refused");
    a_busy_blocks: assert property (busy && load_req_in.valid
        && load_req_in.addr < section_cfg_in.halting_start |=> load_block_out) else $error("busy section read");
    a_busy_cause: assert property ($rose(busy) |-> $past(store_req_in.valid))
        else $error("busy without store");
    a_irq_app: assert property (!pc_ldr && !locks_out.application_lock_pair.read_lock
        && section_cfg_in.vectors_in_loader |=> irq_disable_out) else $error("irq on in app");
    a_irq_ldr: assert property (pc_ldr && !locks_out.loader_lock_pair.read_lock
        && !section_cfg_in.vectors_in_loader |=> irq_disable_out) else $error("irq on in loader");
    a_erase_unlocks: assert property (chip_erase_in |=> locks_out == 6'h3f)
        else $error("locks kept");

    c_halt: cover property ($rose(core_halt_out));
    c_busy: cover property ($rose(busy));
    c_block: cover property (load_block_out);
endmodule // flash_guard_props

bind flash_section_access_guard flash_guard_props u_props (.core_clk_in, .rst_in, .store_req_in, .load_req_in,
    .exec_pc_in, .section_cfg_in, .chip_erase_in, .flash_done_in, .flash_cmd_out, .core_halt_out, .load_grant_out,
    .load_block_out, .store_refused_out, .irq_disable_out, .concurrent_section_busy_flag_out, .locks_out);

// ### flash_array_model.sv
// Purpose: Flash array that ends erase and write after a delay
// Assumes: Same clock as the guard
// Notes: delay_in of 1 answers promptly, larger is slow
module flash_array_model (
    input wire logic core_clk_in, // Clock
    input wire logic rst_in, // Reset
    input flash_guard_pkg::flash_cmd_t flash_cmd_in, // Commands
    input wire logic [7:0] delay_in, // Busy cycles
    output logic flash_done_out // Done pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] count_reg;
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= 8'h00;
            flash_done_out <= 1'b0;
        end else begin
            flash_done_out <= (count_reg == 8'h01);
            if (flash_cmd_in.erase || flash_cmd_in.write) begin
                count_reg <= delay_in;
            end else if (count_reg != 8'h00) begin
                count_reg <= count_reg - 8'h01;
            end
        end
    end
endmodule // flash_array_model

// ### tb_top.sv
// Purpose: Self-checking bench for the flash section access guard
// Assumes: Loader from 0x3000, halting section from 0x2000
// Notes: Outputs are sampled at the edge, before its updates land
`include "flash_guard_defines.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_guard_pkg::*;
    localparam flash_addr_t ldr_pc = 16'h3100;
    localparam flash_addr_t app_pc = 16'h0100;
    logic core_clk_in, rst_in, reg_wr_in, reg_rd_in, ext_lock_wr_in, chip_erase_in, flash_done_in;
    logic core_halt_out, load_grant_out, load_block_out, store_refused_out, irq_disable_out;
    logic concurrent_section_busy_flag_out;
    logic [7:0] reg_addr_in, delay;
    logic [31:0] reg_wdata_in, reg_rdata_out;
    logic [5:0] ext_lock_data_in;
    store_req_t store_req_in;
    load_req_t load_req_in;
    flash_addr_t exec_pc_in;
    section_cfg_t section_cfg_in;
    flash_cmd_t flash_cmd_out;
    lock_bits_t locks_out;
    int fail_count = 0;
    int check_count = 0;

    flash_section_access_guard dut (.core_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .store_req_in, .load_req_in, .exec_pc_in, .section_cfg_in, .ext_lock_wr_in,
        .ext_lock_data_in, .chip_erase_in, .flash_done_in, .flash_cmd_out, .core_halt_out, .load_grant_out,
        .load_block_out, .store_refused_out, .irq_disable_out, .concurrent_section_busy_flag_out, .locks_out);
    flash_array_model m_flash (.core_clk_in, .rst_in, .flash_cmd_in(flash_cmd_out), .delay_in(delay),
        .flash_done_out(flash_done_in));

    always #12.5 core_clk_in = ~core_clk_in;

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        @(posedge core_clk_in);
        chk(reg_rdata_out, exp);
    endtask

    // Ends where the answer cycle is visible
    task automatic store(input store_op_t op, input flash_addr_t a, input flash_addr_t p, input logic [5:0] d);
        @(posedge core_clk_in);
        store_req_in <= '{1'b1, op, a, p, d};
        @(posedge core_clk_in);
        store_req_in.valid <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic load(input flash_addr_t a, input flash_addr_t p, input logic grant);
        @(posedge core_clk_in);
        load_req_in <= '{1'b1, a, p};
        @(posedge core_clk_in);
        load_req_in.valid <= 1'b0;
        @(posedge core_clk_in);
        chk({load_grant_out, load_block_out}, {grant, ~grant});
    endtask

    task automatic wait_done();
        int i = 0;
        do begin
            @(posedge core_clk_in);
            i++;
        end while (flash_done_in !== 1'b1 && i < 300);
        chk(flash_done_in, 1'b1);
    endtask

    task automatic pulse_erase();
        chip_erase_in <= 1'b1;
        tick(1);
        chip_erase_in <= 1'b0;
        tick(2);
    endtask

    initial begin
        repeat (5000) @(posedge core_clk_in);
        fail_count++;
        final_report();
    end

    initial begin
        core_clk_in = 1'b0;
        rst_in = 1'b1;
        {reg_wr_in, reg_rd_in, ext_lock_wr_in, chip_erase_in} = 4'h0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 32'h0000_0000;
        ext_lock_data_in = 6'h3f;
        store_req_in = '0;
        load_req_in = '0;
        exec_pc_in = ldr_pc;
        section_cfg_in = '{16'h3000, 16'h2000, 1'b1};
        delay = 8'h14;
        tick(5);
        rst_in <= 1'b0;
        tick(1);
        chk(locks_out, 6'h3f);
        reg_read(8'h00, 32'h0000_003f);
        reg_read(8'h08, 32'h0000_0000);
        reg_read(8'h10, 32'h0000_0000);
        $display("reset done");
        store(STORE_ERASE, 16'h2400, ldr_pc, 6'h00);
        chk({flash_cmd_out.erase, core_halt_out, flash_cmd_out.addr}, {2'b11, 16'h2400});
        reg_read(8'h08, 32'h0000_000e);
        wait_done();
        tick(1);
        chk(core_halt_out, 1'b0);
        $display("halting erase done");
        delay <= 8'h0c;
        store(STORE_WRITE, 16'h0400, ldr_pc, 6'h00);
        chk({flash_cmd_out.write, core_halt_out, concurrent_section_busy_flag_out}, 3'b101);
        load(16'h2400, ldr_pc, 1'b1);
        load(16'h0400, ldr_pc, 1'b0);
        wait_done();
        tick(1);
        chk(concurrent_section_busy_flag_out, 1'b1);
        reg_write(8'h04, 32'h0000_0001);
        tick(1);
        chk(concurrent_section_busy_flag_out, 1'b0);
        delay <= 8'h01;
        store(STORE_ERASE, 16'h0400, ldr_pc, 6'h00);
        wait_done();
        store(STORE_BUF_LOAD, 16'h0400, ldr_pc, 6'h00);
        chk({flash_cmd_out.buf_load, concurrent_section_busy_flag_out}, 2'b10);
        store(STORE_ERASE, 16'h0400, app_pc, 6'h00);
        chk({flash_cmd_out.erase, store_refused_out}, 2'b01);
        $display("concurrent section done");
        reg_write(8'h00, 32'h0000_000f);
        tick(1);
        chk(locks_out, 6'h0f);
        store(STORE_WRITE, 16'h0400, ldr_pc, 6'h00);
        chk(flash_cmd_out.write, 1'b1);
        wait_done();
        store(STORE_REENABLE, 16'h0000, ldr_pc, 6'h00);
        load(16'h0400, ldr_pc, 1'b1);
        $display("general locks done");
        pulse_erase();
        ext_lock_data_in <= 6'h3e;
        ext_lock_wr_in <= 1'b1;
        tick(1);
        ext_lock_wr_in <= 1'b0;
        tick(2);
        chk(locks_out, 6'h3e);
        store(STORE_WRITE, 16'h2fff, ldr_pc, 6'h00);
        chk({flash_cmd_out.write, store_refused_out}, 2'b01);
        load(16'h2fff, ldr_pc, 1'b1);
        store(STORE_LOCK_SET, 16'h0000, ldr_pc, 6'h3c);
        chk(locks_out, 6'h3c);
        load(16'h2fff, ldr_pc, 1'b0);
        load(16'h2fff, app_pc, 1'b1);
        exec_pc_in <= app_pc;
        tick(2);
        chk(irq_disable_out, 1'b1);
        exec_pc_in <= ldr_pc;
        tick(2);
        chk(irq_disable_out, 1'b0);
        pulse_erase();
        chk(locks_out, 6'h3f);
        reg_write(8'h00, 32'h0000_003d);
        load(16'h0000, ldr_pc, 1'b0);
        $display("application locks done");
        pulse_erase();
        reg_write(8'h00, 32'h0000_003b);
        store(STORE_ERASE, 16'h3000, ldr_pc, 6'h00);
        chk({flash_cmd_out.erase, store_refused_out}, 2'b01);
        load(16'h3000, app_pc, 1'b1);
        reg_write(8'h00, 32'h0000_0033);
        load(16'h3000, app_pc, 1'b0);
        load(16'h3000, ldr_pc, 1'b1);
        section_cfg_in.vectors_in_loader <= 1'b0;
        tick(2);
        chk(irq_disable_out, 1'b1);
        exec_pc_in <= app_pc;
        tick(2);
        chk(irq_disable_out, 1'b0);
        $display("loader locks done");
        final_report();
    end
endmodule // tb_top
